// *** src/rsse_exec.sv ***
// rsse_exec: executes reverse-subtract-immediate, the four delayed returns
// and store byte; holds machine state, exception status and irq registers.
// assumes issue operands, translation results and irq inputs are
// synchronous to pclk and valid in the cycle issue_valid is high.
`default_nettype none
// What this block does
// RULE1 - rD gets sext imm plus inverted rA
// RULE2 - keep bit three holds carry, else loads carry
// RULE3 - carry-in bit four uses carry flag
// RULE4 - carry after subtract means no borrow
// RULE5 - immediate sign-extended unless upper prefix precedes
// RULE6 - break return branches, clears break flag, restores modes
// RULE7 - every return executes one delay slot first
// RULE8 - slot runs with breaks or interrupts disabled
// RULE9 - interrupt return branches, sets enable, restores modes
// RULE10 - low-latency mode acknowledge goes 10 then 11
// RULE11 - user-mode privileged return raises cause 00111
// RULE12 - exception return re-enables exceptions, clears status
// RULE13 - exception return exists only when configured
// RULE14 - interrupts and breaks deferred until slot done
// RULE15 - subroutine return takes one, two or three cycles
// RULE16 - store low byte of rD at rA+rB
// RULE17 - reversed store flips address and endianness
// RULE18 - translation miss blocks store, cause 10010
// RULE19 - zone protection blocks store, cause 10000
module rsse_exec #(
  parameter int MMU_LEVEL = 1,
  parameter bit EXC_ANY = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire rsse_pkg::rsse_issue_t issue,
  output logic issue_ready,
  input wire logic tlb_miss,
  input wire logic zone_block,
  input wire logic zone_no_access,
  input wire logic page_le,
  input wire logic predict_hit,
  input wire logic irq_req,
  input wire logic ext_brk,
  output rsse_pkg::rsse_wb_t wb,
  output rsse_pkg::rsse_mem_t mem,
  output logic br_valid,
  output logic [31:0] br_target,
  output logic exc_valid,
  output logic [4:0] exc_cause,
  output logic [1:0] irq_ack,
  output logic irq_take,
  output logic brk_take,
  output logic irq
);
  if (MMU_LEVEL < 0 || MMU_LEVEL > 3)
  begin : g_bad_mmu
    $error("rsse_exec: MMU_LEVEL out of range");
  end

  localparam bit HAS_RTED = EXC_ANY || (MMU_LEVEL > 0); // RULE13

  rsse_pkg::rsse_st_t q;
  rsse_pkg::rsse_st_t d;
  logic [31:0] w;
  logic [31:0] imm32;
  logic [31:0] sum;
  logic cout;
  logic cin;
  logic accept;
  logic is_rsubi;
  logic is_ret;
  logic is_sb;
  logic is_imm;
  logic priv;
  logic ret_ok;
  logic lowlat;
  logic [1:0] lat;
  logic [31:0] sb_addr;
  logic sb_le;
  logic apb_acc;
  logic apb_hit;
  logic [31:0] rd_word;
  logic [rsse_pkg::EV_W-1:0] ev;
  logic [rsse_pkg::EV_W-1:0] w1c;

  // save mode bits and drop to privileged real mode on a data fault
  function automatic rsse_pkg::rsse_msr_t trap_msr(input rsse_pkg::rsse_msr_t m);
    rsse_pkg::rsse_msr_t r;
    r = m;
    r.saved_user_mode = m.um;
    r.saved_virtual_protect = m.vm;
    r.um = 1'b0;
    r.vm = 1'b0;
    return r;
  endfunction : trap_msr

  // decode; bit 0 of the documented word is our bit 31
  assign w = issue.word;
  assign accept = issue_valid & q.ready;
  assign is_rsubi = (w[31:29] == rsse_pkg::OPC_RSUBI) && w[rsse_pkg::BIT_ONE];
  assign is_ret = w[31:26] == rsse_pkg::OPC_RET;
  assign is_sb = w[31:26] == rsse_pkg::OPC_SB;
  assign is_imm = w[31:26] == rsse_pkg::OPC_IMM;
  assign lowlat = q.ctrl[rsse_pkg::CTRL_IMODE +: 2] == rsse_pkg::IMODE_LOWLAT;
  assign priv = (MMU_LEVEL >= 1) && q.machine_state_reg.um && (w[25:21] != rsse_pkg::RET_SUB); // RULE11
  assign ret_ok = (w[25:21] == rsse_pkg::RET_SUB) || (w[25:21] == rsse_pkg::RET_INT)
    || (w[25:21] == rsse_pkg::RET_BRK) || ((w[25:21] == rsse_pkg::RET_EXC) && HAS_RTED); // RULE13

  // a preceding prefix supplies the upper half instead of sign bits
  assign imm32 = q.imm_v ? {q.imm_hi, w[15:0]} : {{16{w[15]}}, w[15:0]}; // RULE5
  assign cin = w[rsse_pkg::BIT_C] ? q.machine_state_reg.carry : 1'b1; // RULE3

  rsse_addsub #(
    .W(32)
  ) u_addsub (
    .imm_val(imm32),
    .src_val(issue.op_a),
    .cin(cin),
    .sum(sum),
    .cout(cout)
  );

  // return latency: prediction hit, cache off, or mispredict
  always_comb
  begin
    if (w[25:21] != rsse_pkg::RET_SUB)
      lat = rsse_pkg::LAT_RET;
    else if (!q.ctrl[rsse_pkg::CTRL_BTC])
      lat = rsse_pkg::LAT_NOBTC; // RULE15
    else
      lat = predict_hit ? rsse_pkg::LAT_HIT : rsse_pkg::LAT_MISS; // RULE15
  end

  // store address and byte order; paging overrides the static order
  assign sb_addr = (issue.op_a + issue.op_b)
    ^ {30'h0, w[rsse_pkg::BIT_R] ? rsse_pkg::BYTE_REV : 2'h0}; // RULE17
  assign sb_le = (q.machine_state_reg.vm ? page_le : q.ctrl[rsse_pkg::CTRL_LE]) ^ w[rsse_pkg::BIT_R]; // RULE17

  // apb: one wait cycle, write lands with pready
  assign apb_acc = psel & penable & q.pready;
  assign apb_hit = (paddr == rsse_pkg::OFF_CTRL) || (paddr == rsse_pkg::OFF_MSR)
    || (paddr == rsse_pkg::OFF_ESR) || (paddr == rsse_pkg::OFF_STAT)
    || (paddr == rsse_pkg::OFF_MASK);
  assign w1c = (apb_acc && pwrite && paddr == rsse_pkg::OFF_STAT) ?
    pwdata[rsse_pkg::EV_W-1:0] : '0;

  always_comb
  begin
    case (paddr)
      rsse_pkg::OFF_CTRL: rd_word = {28'h0, q.ctrl};
      rsse_pkg::OFF_MSR: rd_word = {22'h0, q.machine_state_reg};
      rsse_pkg::OFF_ESR: rd_word = {25'h0, q.exception_status_reg};
      rsse_pkg::OFF_STAT: rd_word = {27'h0, q.stat};
      rsse_pkg::OFF_MASK: rd_word = {27'h0, q.mask};
      default: rd_word = 32'h0;
    endcase
  end

  // next state of the whole unit
  always_comb
  begin
    d = q;
    ev = '0;
    d.wb.we = 1'b0;
    d.mem.we = 1'b0;
    d.br_v = 1'b0;
    d.exc_v = 1'b0;
    d.itake = 1'b0;
    d.btake = 1'b0;
    d.pready = psel & penable & ~q.pready;
    if (psel && penable && !q.pready)
    begin
      d.prdata = pwrite ? 32'h0 : rd_word;
      d.pslverr = ~apb_hit;
    end
    // software writes first; instruction effects of this cycle win
    if (apb_acc && pwrite)
    begin
      case (paddr)
        rsse_pkg::OFF_CTRL: d.ctrl = pwdata[3:0];
        rsse_pkg::OFF_MSR: d.machine_state_reg = pwdata[9:0];
        rsse_pkg::OFF_MASK: d.mask = pwdata[rsse_pkg::EV_W-1:0];
        default: d.ctrl = d.ctrl;
      endcase
    end
    case (q.st)
      rsse_pkg::ST_IDLE:
      begin
        // no pending return here, so events may be taken
        if (!accept && !q.imm_v)
        begin
          if (ext_brk && !q.machine_state_reg.break_in_progress)
          begin
            d.btake = 1'b1; // RULE14
            d.machine_state_reg.break_in_progress = 1'b1;
          end
          else if (irq_req && q.machine_state_reg.ie)
          begin
            d.itake = 1'b1; // RULE14
            d.machine_state_reg.ie = 1'b0;
          end
        end
      end
      rsse_pkg::ST_STALL:
      begin
        d.stall = q.stall - 2'h1;
        if (q.stall == 2'h1)
        begin
          d.st = rsse_pkg::ST_SLOT;
          d.ready = 1'b1;
        end
      end
      rsse_pkg::ST_SLOT: d.st = rsse_pkg::ST_SLOT; // wait for the slot instruction
      default:
      begin
        d.st = rsse_pkg::ST_IDLE;
        d.ready = 1'b1;
      end
    endcase
    if (accept)
    begin
      d.imm_v = 1'b0;
      if (is_imm)
      begin
        d.imm_v = 1'b1;
        d.imm_hi = w[15:0];
      end
      else if (is_rsubi)
      begin
        d.wb.we = 1'b1;
        d.wb.idx = w[25:21];
        d.wb.data = sum; // RULE1
        if (!w[rsse_pkg::BIT_K])
          d.machine_state_reg.carry = cout; // RULE2 RULE4
      end
      else if (is_sb)
      begin
        if (q.machine_state_reg.vm && tlb_miss)
        begin
          d.exc_v = 1'b1; // RULE18
          d.exception_status_reg.ec = rsse_pkg::EC_TLB;
          d.exception_status_reg.s = 1'b1;
          d.machine_state_reg = trap_msr(d.machine_state_reg);
          ev[rsse_pkg::EV_TLB] = 1'b1;
        end
        else if (q.machine_state_reg.vm && zone_block)
        begin
          d.exc_v = 1'b1; // RULE19
          d.exception_status_reg.ec = rsse_pkg::EC_DSTOR;
          d.exception_status_reg.s = 1'b1;
          d.exception_status_reg.zone_fault_flag = zone_no_access;
          d.machine_state_reg = trap_msr(d.machine_state_reg);
          ev[rsse_pkg::EV_DSTOR] = 1'b1;
        end
        else
        begin
          d.mem.we = 1'b1; // RULE16
          d.mem.addr = sb_addr;
          d.mem.data = {4{issue.op_d[7:0]}};
          d.mem.be = 4'h1 << (sb_le ? sb_addr[1:0] : ~sb_addr[1:0]); // RULE17
          ev[rsse_pkg::EV_STORE] = 1'b1;
        end
      end
      else if (is_ret && ret_ok && q.st == rsse_pkg::ST_IDLE)
      begin
        if (priv)
        begin
          d.exc_v = 1'b1; // RULE11
          d.exception_status_reg.ec = rsse_pkg::EC_PRIV;
          ev[rsse_pkg::EV_PRIV] = 1'b1;
        end
        else
        begin
          d.kind = w[25:21];
          d.tgt = issue.op_a + imm32; // RULE6 RULE9 RULE12
          if (lat == rsse_pkg::LAT_HIT)
            d.st = rsse_pkg::ST_SLOT; // RULE7
          else
          begin
            d.st = rsse_pkg::ST_STALL; // RULE15
            d.stall = lat - 2'h1;
            d.ready = 1'b0;
          end
          if (w[25:21] == rsse_pkg::RET_INT && lowlat)
            d.ack = rsse_pkg::ACK_RET; // RULE10
        end
      end
      // slot done: the branch and the mode restore take effect now
      if (q.st == rsse_pkg::ST_SLOT)
      begin
        d.st = rsse_pkg::ST_IDLE; // RULE7
        if (d.exc_v)
          d.machine_state_reg.ds = 1'b1; // faulting slot leaves branch to the handler
        else
        begin
          d.br_v = 1'b1;
          d.br_tgt = q.tgt;
          ev[rsse_pkg::EV_RET] = 1'b1;
          if (q.kind != rsse_pkg::RET_SUB)
          begin
            d.machine_state_reg.um = q.machine_state_reg.saved_user_mode;
            d.machine_state_reg.vm = q.machine_state_reg.saved_virtual_protect;
          end
          case (q.kind)
            rsse_pkg::RET_BRK: d.machine_state_reg.break_in_progress = 1'b0; // RULE6 RULE8
            rsse_pkg::RET_INT:
            begin
              d.machine_state_reg.ie = 1'b1; // RULE8 RULE9
              if (lowlat)
                d.ack = rsse_pkg::ACK_IE; // RULE10
            end
            rsse_pkg::RET_EXC:
            begin
              d.machine_state_reg.ee = 1'b1; // RULE12
              d.machine_state_reg.exception_in_progress = 1'b0;
              d.machine_state_reg.ds = 1'b0;
              d.exception_status_reg = '0;
            end
            default: d.kind = q.kind;
          endcase
        end
      end
    end
    // a new event wins over a clear in the same cycle
    d.stat = (q.stat & ~w1c) | ev;
    d.irq = |(d.stat & d.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.st <= rsse_pkg::ST_IDLE;
      q.ready <= 1'b1;
      q.machine_state_reg <= rsse_pkg::MSR_RST;
      q.ctrl <= rsse_pkg::CTRL_RST;
      q.mask <= rsse_pkg::MASK_RST;
      q.ack <= rsse_pkg::ACK_RST;
    end
    else
      q <= d;
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign issue_ready = q.ready;
  assign wb = q.wb;
  assign mem = q.mem;
  assign br_valid = q.br_v;
  assign br_target = q.br_tgt;
  assign exc_valid = q.exc_v;
  assign exc_cause = q.exception_status_reg.ec;
  assign irq_ack = q.ack;
  assign irq_take = q.itake;
  assign brk_take = q.btake;
  assign irq = q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RSUB_RESULT: assert property (accept && is_rsubi |=> q.wb.we // RULE1
    && q.wb.data == $past(imm32) + ~$past(issue.op_a) + {31'h0, $past(cin)})
    else $error("reverse subtract result wrong");
  AST_KEEP_CARRY: assert property (accept && is_rsubi && w[rsse_pkg::BIT_K] // RULE2
    |=> $stable(q.machine_state_reg.carry))
    else $error("keep-carry form changed carry");
  AST_CARRY_IN: assert property (accept && is_rsubi && w[rsse_pkg::BIT_C] // RULE3
    |-> cin == q.machine_state_reg.carry)
    else $error("carry-in not taken from flag");
  AST_NO_BORROW: assert property (accept && is_rsubi && !w[rsse_pkg::BIT_K] // RULE4
    |=> q.machine_state_reg.carry == ($past({1'b0, imm32}) + $past({1'b0, ~issue.op_a})
    + {32'h0, $past(cin)}) >> 32)
    else $error("carry is not the inverse of borrow");
  AST_IMM_SEXT: assert property (!q.imm_v |-> imm32[31:16] == {16{w[15]}}) // RULE5
    else $error("immediate not sign extended");
  AST_BRK_DONE: assert property (q.st == rsse_pkg::ST_SLOT && accept // RULE6
    && q.kind == rsse_pkg::RET_BRK && !(is_sb && q.machine_state_reg.vm && (tlb_miss || zone_block))
    |=> !q.machine_state_reg.break_in_progress && q.br_v && q.br_tgt == $past(q.tgt))
    else $error("break return did not complete");
  AST_SLOT_FIRST: assert property (accept && is_ret && ret_ok && !priv // RULE7
    && q.st == rsse_pkg::ST_IDLE |=> !q.br_v ##1 (!q.br_v || $past(accept)))
    else $error("branch before delay slot");
  AST_SLOT_IE_OFF: assert property (q.st != rsse_pkg::ST_IDLE // RULE8
    && q.kind == rsse_pkg::RET_INT && !$rose(q.st == rsse_pkg::ST_STALL) |-> !q.itake)
    else $error("interrupt taken inside return");
  AST_ACK_RET: assert property (accept && is_ret && w[25:21] == rsse_pkg::RET_INT // RULE10
    && !priv && lowlat && q.st == rsse_pkg::ST_IDLE |=> q.ack == rsse_pkg::ACK_RET)
    else $error("acknowledge not 10 on interrupt return");
  AST_PRIV: assert property (accept && is_ret && ret_ok && priv // RULE11
    && q.st == rsse_pkg::ST_IDLE |=> q.exc_v && q.exception_status_reg.ec == rsse_pkg::EC_PRIV
    && q.st == rsse_pkg::ST_IDLE)
    else $error("privileged return not trapped");
  AST_DEFER: assert property (q.st != rsse_pkg::ST_IDLE |=> !q.itake && !q.btake) // RULE14
    else $error("event taken during return");
  AST_RTSD_MISS: assert property (accept && is_ret && w[25:21] == rsse_pkg::RET_SUB // RULE15
    && q.st == rsse_pkg::ST_IDLE && q.ctrl[rsse_pkg::CTRL_BTC] && !predict_hit
    |=> !q.ready ##1 !q.ready ##1 q.ready)
    else $error("mispredicted return not three cycles");
  AST_SB_DATA: assert property (accept && is_sb && !q.machine_state_reg.vm // RULE16
    |=> q.mem.we && q.mem.data[7:0] == $past(issue.op_d[7:0]))
    else $error("store byte data wrong");
  AST_TLB: assert property (accept && is_sb && q.machine_state_reg.vm && tlb_miss // RULE18
    |=> !q.mem.we && q.exception_status_reg.ec == rsse_pkg::EC_TLB && !q.machine_state_reg.vm && q.machine_state_reg.saved_virtual_protect)
    else $error("translation miss not trapped");

  COV_RSUBI: cover property (accept && is_rsubi && w[rsse_pkg::BIT_C]);
  COV_RTID: cover property (q.st == rsse_pkg::ST_SLOT && accept && q.kind == rsse_pkg::RET_INT);
  COV_ZONE: cover property (accept && is_sb && q.machine_state_reg.vm && zone_block && !tlb_miss);
  COV_IRQ: cover property ($rose(q.irq));
endmodule : rsse_exec
`default_nettype wire

// *** src/rsse_pkg.sv ***
// rsse_pkg: register map, field layout, opcodes and state carriers
// of the return / reverse-subtract / store-byte execution unit.
// assumes one 50 MHz core clock and APB access to the registers.
`default_nettype none
package rsse_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MSR = 8'h04;
  localparam logic [7:0] OFF_ESR = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  // control fields: little endian, branch target cache on, irq mode
  localparam int CTRL_LE = 0;
  localparam int CTRL_BTC = 1;
  localparam int CTRL_IMODE = 2;
  localparam logic [3:0] CTRL_RST = 4'h2;
  localparam logic [1:0] IMODE_LOWLAT = 2'h2;
  localparam logic [1:0] ACK_RST = 2'h0;
  localparam logic [1:0] ACK_RET = 2'h2;
  localparam logic [1:0] ACK_IE = 2'h3;
  // opcode fields, instruction bit 0 is the msb
  localparam logic [2:0] OPC_RSUBI = 3'h1;
  localparam logic [5:0] OPC_RET = 6'h2D;
  localparam logic [5:0] OPC_IMM = 6'h2C;
  localparam logic [5:0] OPC_SB = 6'h34;
  localparam int BIT_K = 28;
  localparam int BIT_C = 27;
  localparam int BIT_ONE = 26;
  localparam int BIT_R = 9;
  localparam logic [4:0] RET_SUB = 5'h10;
  localparam logic [4:0] RET_INT = 5'h11;
  localparam logic [4:0] RET_BRK = 5'h12;
  localparam logic [4:0] RET_EXC = 5'h14;
  // exception cause codes
  localparam logic [4:0] EC_PRIV = 5'h07;
  localparam logic [4:0] EC_TLB = 5'h12;
  localparam logic [4:0] EC_DSTOR = 5'h10;
  // sticky event bits
  localparam int EV_STORE = 0;
  localparam int EV_PRIV = 1;
  localparam int EV_TLB = 2;
  localparam int EV_DSTOR = 3;
  localparam int EV_RET = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  // cycles a return occupies the issue port
  localparam logic [1:0] LAT_HIT = 2'h1;
  localparam logic [1:0] LAT_NOBTC = 2'h2;
  localparam logic [1:0] LAT_MISS = 2'h3;
  localparam logic [1:0] LAT_RET = 2'h2;
  localparam logic [1:0] BYTE_REV = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STALL = 3'b010,
    ST_SLOT = 3'b100
  } rsse_fsm_t;

  typedef struct packed {
    logic ds, exception_in_progress, ee, saved_virtual_protect, vm, saved_user_mode, um, break_in_progress, ie, carry;
  } rsse_msr_t;
  localparam rsse_msr_t MSR_RST = 10'h000;

  typedef struct packed {
    logic zone_fault_flag;
    logic s;
    logic [4:0] ec;
  } rsse_esr_t;

  typedef struct packed {
    logic [31:0] word;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [31:0] op_d;
  } rsse_issue_t;

  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [31:0] data;
  } rsse_wb_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } rsse_mem_t;

  typedef struct packed {
    rsse_fsm_t st;
    logic [1:0] stall;
    logic imm_v;
    logic [15:0] imm_hi;
    logic [4:0] kind;
    logic [31:0] tgt;
    rsse_msr_t machine_state_reg;
    rsse_esr_t exception_status_reg;
    logic [3:0] ctrl;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ready;
    rsse_wb_t wb;
    rsse_mem_t mem;
    logic br_v;
    logic [31:0] br_tgt;
    logic exc_v;
    logic [1:0] ack;
    logic itake;
    logic btake;
    logic irq;
  } rsse_st_t;
endpackage : rsse_pkg
`default_nettype wire

// *** src/rsse_addsub.sv ***
// rsse_addsub: reverse subtract adder, immediate + ~source + carry in.
// assumes operands are stable for the whole cycle; purely combinational.
`default_nettype none
module rsse_addsub #(
  parameter int W = 32
) (
  input wire logic [W-1:0] imm_val,
  input wire logic [W-1:0] src_val,
  input wire logic cin,
  output logic [W-1:0] sum,
  output logic cout
);
  // refuse widths the carry path cannot serve
  if (W < 2)
  begin : g_bad_width
    $error("rsse_addsub: W must be at least 2");
  end

  // carry out is the inverse of borrow
  assign {cout, sum} = {1'b0, imm_val} + {1'b0, ~src_val} + {{W{1'b0}}, cin}; // RULE4
endmodule : rsse_addsub
`default_nettype wire

// *** bench/rsse_partner.sv ***
// rsse_partner: store sink and interrupt source beside rsse_exec.
// assumes a pclk-synchronous store port with replicated byte lanes.
`default_nettype none
module rsse_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire rsse_pkg::rsse_mem_t mem,
  input wire logic raise,
  input wire logic irq_take,
  output logic irq_req,
  output logic [31:0] last_addr,
  output logic [11:0] last_lane,
  output int n_take
);
  timeunit 1ns;
  timeprecision 1ns;
  // keep the last store: address, lane enables, byte
  always @(posedge pclk)
  begin
    if (mem.we)
    begin
      last_addr <= mem.addr;
      last_lane <= {mem.be, mem.data[7:0]};
    end
  end
  // level request held until the core accepts it, never dropped early
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req <= 1'b0;
      n_take <= 0;
    end
    else if (irq_take)
    begin
      irq_req <= 1'b0;
      n_take <= n_take + 1;
    end
    else if (raise)
      irq_req <= 1'b1;
  end
endmodule : rsse_partner
`default_nettype wire

// *** bench/rsse_exec_tb.sv ***
// rsse_exec_tb: self-checking bench for rsse_exec, one task per scenario.
// assumes rsse_partner as store sink and irq source, default parameters.
`default_nettype none
module rsse_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, cy;
  logic issue_valid, issue_ready, tlb_miss, zone_block, zone_no_access;
  logic page_le, predict_hit, irq_req, ext_brk, br_valid, exc_valid;
  logic irq_take, brk_take, irq, raise;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, br_target, rd, la;
  logic [4:0] exc_cause;
  logic [1:0] irq_ack;
  logic [11:0] ll;
  rsse_pkg::rsse_issue_t issue;
  rsse_pkg::rsse_wb_t wb;
  rsse_pkg::rsse_mem_t mem;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int ntk;
  int nbk = 0;

  rsse_exec i_rsse_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .issue_valid, .issue, .issue_ready, .tlb_miss,
    .zone_block, .zone_no_access, .page_le, .predict_hit, .irq_req, .ext_brk,
    .wb, .mem, .br_valid, .br_target, .exc_valid, .exc_cause, .irq_ack,
    .irq_take, .brk_take, .irq);
  rsse_partner i_rsse_partner (.pclk, .presetn, .mem, .raise, .irq_take,
    .irq_req, .last_addr(la), .last_lane(ll), .n_take(ntk));

  // 50 MHz core clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    // count accepted breaks, each a one-cycle pulse
    if (brk_take === 1'b1)
      nbk <= nbk + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // offer one instruction; returns one edge after it was taken
  task automatic iss(input logic [31:0] w, a, b, d);
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue <= '{w, a, b, d};
    do @(posedge pclk); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    @(posedge pclk);
  endtask : iss

  function automatic logic [31:0] wsub(logic k, logic c, logic [15:0] im);
    return {rsse_pkg::OPC_RSUBI, k, c, 1'b1, 5'h03, 5'h04, im};
  endfunction : wsub

  function automatic logic [31:0] wret(logic [4:0] s);
    return {rsse_pkg::OPC_RET, s, 5'h0E, 16'hFFF8};
  endfunction : wret

  task automatic t_reset();
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i == 0) ? {28'h0, rsse_pkg::CTRL_RST} : 32'h0);
      chk(perr, i == 5);
    end
  endtask : t_reset

  // carry kept in cy, worked out from a 33-bit sum
  task automatic t_rsub(input logic k, c, input logic [15:0] im, input logic [31:0] a, x);
    logic [32:0] s;
    s = {1'b0, x} + {1'b0, ~a} + (c ? {32'h0, cy} : 33'h1);
    iss(wsub(k, c, im), a, 32'h0, 32'h0);
    chk({wb.we, wb.idx}, 6'h23);
    chk(wb.data, s[31:0]);
    if (!k)
      cy = s[32];
    apb(1'b0, rsse_pkg::OFF_MSR, 32'h0);
    chk(rd, {31'h0, cy});
  endtask : t_rsub

  // return, stall count, delay slot, then branch and restored state
  task automatic t_ret(input logic [4:0] s, input int stl, input logic [31:0] m);
    int n;
    iss(wret(s), 32'h100, 32'h0, 32'h0);
    chk(br_valid, 1'b0);
    if (s == rsse_pkg::RET_INT)
      chk(irq_ack, rsse_pkg::ACK_RET);
    n = 0;
    while (issue_ready !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge pclk);
    end
    chk(n, stl);
    iss(wsub(1'b1, 1'b0, 16'h0010), 32'h0, 32'h0, 32'h0);
    chk({br_valid, wb.we, irq_take}, 3'b110);
    chk(br_target, 32'hF8);
    if (s == rsse_pkg::RET_INT)
      chk(irq_ack, rsse_pkg::ACK_IE);
    apb(1'b0, rsse_pkg::OFF_MSR, 32'h0);
    chk(rd, m);
  endtask : t_ret

  // store byte of rD at rA+rB, or a trap with no store
  task automatic t_store(input logic r, le, input logic [4:0] ec);
    logic [31:0] ad;
    ad = 32'h1001 ^ {30'h0, r, r};
    iss({rsse_pkg::OPC_SB, 15'h18C7, 1'b0, r, 9'h000}, 32'h1000, 32'h1, 32'h112233A5);
    chk({mem.we, exc_valid}, {ec == 5'h0, ec != 5'h0});
    // cause field is sticky, so only a trap defines it
    if (ec != 5'h0)
      chk(exc_cause, ec);
    if (ec == 5'h0)
    begin
      @(posedge pclk);
      chk(la, ad);
      chk(ll, {(le ^ r) ? 4'h1 << ad[1:0] : 4'h8 >> ad[1:0], 8'hA5});
    end
  endtask : t_store

  // privileged returns in user mode, sticky status and irq line
  task automatic t_priv();
    logic [4:0] ks [3];
    ks = '{rsse_pkg::RET_INT, rsse_pkg::RET_BRK, rsse_pkg::RET_EXC};
    apb(1'b1, rsse_pkg::OFF_STAT, 32'h1F);
    for (int i = 0; i < 3; i++)
    begin
      iss(wret(ks[i]), 32'h100, 32'h0, 32'h0);
      chk({exc_valid, br_valid, exc_cause}, {2'b10, rsse_pkg::EC_PRIV});
    end
    chk(irq, 1'b0);
    apb(1'b1, rsse_pkg::OFF_MASK, 32'h2);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, rsse_pkg::OFF_STAT, 32'h2);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
  endtask : t_priv

  // main sequence; ext_brk raised across the break return only
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, issue_valid, issue, tlb_miss,
      zone_block, zone_no_access, page_le, predict_hit, ext_brk, raise, cy} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rsub(1'b0, 1'b0, 16'h0001, 32'h2, 32'h1);
    t_rsub(1'b0, 1'b1, 16'h0005, 32'h3, 32'h5);
    t_rsub(1'b1, 1'b1, 16'h0005, 32'h3, 32'h5);
    t_rsub(1'b1, 1'b0, 16'h8000, 32'h0, 32'hFFFF8000);
    iss({rsse_pkg::OPC_IMM, 10'h0, 16'h1234}, 32'h0, 32'h0, 32'h0);
    t_rsub(1'b0, 1'b0, 16'h0000, 32'h0, 32'h12340000);
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h0);
    predict_hit <= 1'b1;
    t_ret(rsse_pkg::RET_SUB, 0, 32'h0);
    predict_hit <= 1'b0;
    t_ret(rsse_pkg::RET_SUB, 2, 32'h0);
    apb(1'b1, rsse_pkg::OFF_CTRL, 32'h0);
    t_ret(rsse_pkg::RET_SUB, 1, 32'h0);
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h4);
    ext_brk <= 1'b1;
    t_ret(rsse_pkg::RET_BRK, 1, 32'h4);
    ext_brk <= 1'b0;
    chk(nbk, 32'h1);
    apb(1'b1, rsse_pkg::OFF_CTRL, 32'hA);
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h50);
    raise <= 1'b1;
    t_ret(rsse_pkg::RET_INT, 1, 32'h78);
    chk(ntk, 32'h1);
    raise <= 1'b0;
    t_priv();
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h0);
    apb(1'b1, rsse_pkg::OFF_CTRL, 32'h2);
    t_store(1'b0, 1'b0, 5'h0);
    t_store(1'b1, 1'b0, 5'h0);
    apb(1'b1, rsse_pkg::OFF_CTRL, 32'h3);
    t_store(1'b0, 1'b1, 5'h0);
    apb(1'b1, rsse_pkg::OFF_CTRL, 32'h2);
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h28);
    page_le <= 1'b1;
    t_store(1'b0, 1'b1, 5'h0);
    tlb_miss <= 1'b1;
    t_store(1'b0, 1'b1, rsse_pkg::EC_TLB);
    apb(1'b0, rsse_pkg::OFF_MSR, 32'h0);
    chk(rd, 32'h50);
    apb(1'b0, rsse_pkg::OFF_ESR, 32'h0);
    chk(rd, 32'h32);
    tlb_miss <= 1'b0;
    zone_block <= 1'b1;
    zone_no_access <= 1'b1;
    apb(1'b1, rsse_pkg::OFF_MSR, 32'h28);
    t_store(1'b0, 1'b1, rsse_pkg::EC_DSTOR);
    apb(1'b0, rsse_pkg::OFF_MSR, 32'h0);
    chk(rd, 32'h50);
    apb(1'b0, rsse_pkg::OFF_ESR, 32'h0);
    chk(rd, 32'h70);
    t_ret(rsse_pkg::RET_EXC, 1, 32'hF8);
    apb(1'b0, rsse_pkg::OFF_ESR, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule : rsse_exec_tb
`default_nettype wire
